// ---- mebpc_pkg.sv ----
// Shared constants and types for the external bus pin controller.
// Assumes one core clock; the core issues one bus request per machine cycle.
// What this block does
// - One address latch pulse is issued in every machine cycle.
// - Address is on the bus before the latch pulse falls.
// - Code fetch strobe is low only for external program fetches.
// - External fetch drives low counter byte, then reads the code byte.
// - External fetch drives high counter nibble on port two low nibble.
// - Port two low nibble is an expander bus timed by its strobe.
// - Bus is read or written under strobes, or statically latched.
// - Data store places address, then data, under latch and write strobe.
// - Read strobe is low during bus inputs and external data reads.
// - Write strobe is low during bus writes and external data writes.
// - Ports one and two are quasi bidirectional eight bit ports.
// - Reset initialises everything and leaves the interrupt disabled.
// - Interrupt pin requests only when enabled; its level is testable.
// - Test pin zero is testable, or a clock output once enabled.
// - Test pin one is testable, or the counter event input once started.
// - Low single step input halts after each instruction.
// - External access input forces every program fetch external.
package mebpc_pkg;
   // ----------------------------------------
   // Machine cycle ticks
   // ----------------------------------------
   localparam logic [3:0] TICK_LAST = 4'hE;
   localparam logic [3:0] TICK_PRE = 4'hD;
   localparam logic [3:0] ALE_END = 4'h3;
   localparam logic [3:0] ADDR_END = 4'h4;
   localparam logic [3:0] STB_ON = 4'h5;
   localparam logic [3:0] SAMPLE = 4'hB;
   localparam logic [3:0] STB_OFF = 4'hC;
   localparam logic [3:0] DATA_END = 4'hE;
   localparam logic [3:0] EXP_OFF = 4'h6;
   // ----------------------------------------
   // Sizes and reset values
   // ----------------------------------------
   localparam logic [11:0] INT_CODE_SIZE = 12'h400;
   localparam logic [7:0] PORT_RST = 8'hFF;
   localparam logic [7:0] BUS_RST = 8'h00;
   localparam logic STRB_IDLE = 1'b1;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      MEBPC_IDLE, MEBPC_FETCH, MEBPC_DATA_RD, MEBPC_DATA_WR, MEBPC_BUS_RD,
      MEBPC_BUS_WR, MEBPC_PORT_RD, MEBPC_PORT_WR, MEBPC_EXP_RD, MEBPC_EXP_WR
   } mebpc_op_t;
   typedef enum logic {MEBPC_RUN, MEBPC_HOLD} mebpc_state_t;
   typedef struct packed {
      mebpc_op_t op;
      logic [11:0] addr;
      logic [7:0] wdata;
      logic [1:0] exp_code;
      logic [1:0] exp_port;
      logic port_two;
      logic last;
   } mebpc_req_t;
   typedef struct packed {
      logic done;
      logic [7:0] rdata;
   } mebpc_resp_t;
   typedef struct packed {
      logic int_enable;
      logic int_disable;
      logic clkout_enable_instr;
      logic counter_start_instr;
   } mebpc_ctl_t;
   typedef struct packed {
      logic jump_if_test_zero_high;
      logic jump_if_test_zero_low;
      logic jump_if_test_one_high;
      logic jump_if_test_one_low;
      logic int_level;
      logic int_request;
      logic counter_event;
      logic halted;
   } mebpc_stat_t;
   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe;
   } mebpc_pin8_t;
endpackage : mebpc_pkg

// ---- mebpc_top.sv ----
// Pin control for the multiplexed external bus, ports and test inputs.
// Assumes all pin inputs are synchronous to core_clk and the core
// presents a request whenever req_take is high.
`timescale 1ns/100ps
`default_nettype none
module mebpc_top
   import mebpc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire mebpc_req_t req,
   output logic req_take,
   output mebpc_resp_t resp,
   input wire mebpc_ctl_t ctl,
   output mebpc_stat_t stat,
   input wire logic [7:0] int_code_byte,
   input wire logic [7:0] muxed_bus_in,
   output mebpc_pin8_t muxed_bus_pins,
   input wire logic [7:0] port_one_in,
   output mebpc_pin8_t port_one_pins,
   input wire logic [7:0] port_two_in,
   output mebpc_pin8_t port_two_pins,
   output logic addr_latch,
   output logic code_fetch_strobe_n,
   output logic rd_strobe_n,
   output logic wr_strobe_n,
   output logic expander_strobe,
   input wire logic ext_fetch_force,
   input wire logic single_step_n,
   input wire logic int_pin_n,
   input wire logic test_pin_zero_in,
   output logic test_pin_zero_out,
   output logic test_pin_zero_oe,
   input wire logic test_pin_one_in
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic in_win(input logic [3:0] t, input logic [3:0] lo,
                                   input logic [3:0] hi);
      in_win = (t >= lo) && (t < hi);
   endfunction : in_win

   function automatic logic is_ext_fetch(input mebpc_req_t r, input logic force_ext);
      is_ext_fetch = (r.op == MEBPC_FETCH) && (force_ext || (r.addr >= INT_CODE_SIZE));
   endfunction : is_ext_fetch

   // ----------------------------------------
   // State
   // ----------------------------------------
   mebpc_state_t state;
   mebpc_state_t next_state;
   logic [3:0] tick;
   logic [3:0] next_tick;
   mebpc_req_t cur;
   mebpc_req_t nop;
   logic [7:0] p1_latch;
   logic [7:0] p2_latch;
   logic [7:0] static_val;
   logic static_on;
   logic int_en;
   logic clkout_mode;
   logic count_mode;
   logic one_prev;
   logic next_take;
   logic active;
   logic n_ext;
   logic n_mem;
   logic n_exp;
   logic n_stb;
   logic n_rd_op;
   logic n_wr_op;
   logic n_addr_win;
   logic n_ext_win;
   logic n_cmd_win;
   logic n_xwr_win;
   logic n_xrd_win;
   logic stop_req;
   logic [7:0] n_bus_val;
   logic n_bus_oe;
   logic [3:0] n_p2_val;
   logic [3:0] n_p2_oe;
   logic [7:0] sample_val;
   mebpc_stat_t next_stat;

   // ----------------------------------------
   // Cycle sequencing
   // ----------------------------------------
   // Tick count runs 0..TICK_LAST; a new request is taken only at the boundary
   assign stop_req = cur.last && !single_step_n;
   assign next_take = req_take ? 1'b0 :
                      (state == MEBPC_RUN) ? ((tick == TICK_PRE) && !stop_req) :
                      single_step_n;
   assign next_state = req_take ? MEBPC_RUN :
                       ((state == MEBPC_RUN) && (tick == TICK_LAST)) ? MEBPC_HOLD :
                       state;
   assign next_tick = req_take ? 4'h0 :
                      ((state == MEBPC_RUN) && (tick != TICK_LAST)) ? tick + 4'h1 :
                      tick;
   assign nop = req_take ? req : cur;
   assign active = (next_state == MEBPC_RUN);

   // ----------------------------------------
   // Decode of the coming tick
   // ----------------------------------------
   assign n_ext = is_ext_fetch(nop, ext_fetch_force);
   assign n_mem = n_ext || (nop.op == MEBPC_DATA_RD) || (nop.op == MEBPC_DATA_WR);
   assign n_exp = (nop.op == MEBPC_EXP_RD) || (nop.op == MEBPC_EXP_WR);
   assign n_stb = active && in_win(next_tick, STB_ON, STB_OFF);
   assign n_rd_op = (nop.op == MEBPC_DATA_RD) || (nop.op == MEBPC_BUS_RD);
   assign n_wr_op = (nop.op == MEBPC_DATA_WR) || (nop.op == MEBPC_BUS_WR);

   // Pin windows of the coming tick, shared by level and enable so they cannot drift
   assign n_addr_win = active && n_mem && (next_tick < ADDR_END);
   assign n_ext_win = active && n_ext && (next_tick < DATA_END);
   assign n_cmd_win = active && n_exp && (next_tick < EXP_OFF);
   assign n_xwr_win = active && (nop.op == MEBPC_EXP_WR) && (next_tick < DATA_END);
   assign n_xrd_win = active && (nop.op == MEBPC_EXP_RD) && (next_tick < DATA_END);

   // Bus: address first, then write data, released for reads and memory ops, else the static latch, else released
   assign n_bus_oe = !active ? static_on :
                     n_addr_win ? 1'b1 :
                     ((nop.op == MEBPC_DATA_WR) &&
                      in_win(next_tick, ADDR_END, DATA_END)) ? 1'b1 :
                     ((nop.op == MEBPC_BUS_WR) && (next_tick < DATA_END)) ? 1'b1 :
                     (n_mem || n_rd_op) ? 1'b0 :
                     static_on;
   assign n_bus_val = n_addr_win ? nop.addr[7:0] :
                      (active && n_wr_op) ? nop.wdata :
                      static_on ? static_val : BUS_RST;

   // Port two low nibble: fetch address, expander command/data, else quasi port
   assign n_p2_val = n_ext_win ? nop.addr[11:8] :
                     n_cmd_win ? {nop.exp_code, nop.exp_port} :
                     n_xwr_win ? nop.wdata[3:0] :
                     p2_latch[3:0];
   assign n_p2_oe = (n_ext_win || n_cmd_win || n_xwr_win) ? 4'hF :
                    n_xrd_win ? 4'h0 :
                    ~p2_latch[3:0];

   // Read data source for the current op, taken in the last strobe tick
   assign sample_val = (cur.op == MEBPC_FETCH) ?
                          (is_ext_fetch(cur, ext_fetch_force) ? muxed_bus_in : int_code_byte) :
                       ((cur.op == MEBPC_DATA_RD) || (cur.op == MEBPC_BUS_RD)) ? muxed_bus_in :
                       (cur.op == MEBPC_EXP_RD) ? {4'h0, port_two_in[3:0]} :
                       (cur.op == MEBPC_PORT_RD) ?
                          (cur.port_two ? port_two_in : port_one_in) :
                       resp.rdata;

   // Status: pin levels for conditional jumps, gated interrupt, counter edge
   assign next_stat.jump_if_test_zero_high = test_pin_zero_in;
   assign next_stat.jump_if_test_zero_low = !test_pin_zero_in;
   assign next_stat.jump_if_test_one_high = test_pin_one_in;
   assign next_stat.jump_if_test_one_low = !test_pin_one_in;
   assign next_stat.int_level = !int_pin_n;
   assign next_stat.int_request = int_en && !int_pin_n;
   assign next_stat.counter_event = count_mode && one_prev && !test_pin_one_in;
   assign next_stat.halted = (next_state == MEBPC_HOLD);

   // ----------------------------------------
   // Sequencer registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= MEBPC_HOLD;
         tick <= TICK_LAST;
         cur <= '0;
         req_take <= 1'b0;
      end
      else
      begin
         state <= next_state;
         tick <= next_tick;
         cur <= nop;
         req_take <= next_take;
      end
   end

   // ----------------------------------------
   // Pin strobes
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_latch <= 1'b0;
         code_fetch_strobe_n <= STRB_IDLE;
         rd_strobe_n <= STRB_IDLE;
         wr_strobe_n <= STRB_IDLE;
         expander_strobe <= STRB_IDLE;
      end
      else
      begin
         addr_latch <= active && (next_tick < ALE_END);
         code_fetch_strobe_n <= !(n_stb && n_ext);
         rd_strobe_n <= !(n_stb && n_rd_op);
         wr_strobe_n <= !(n_stb && n_wr_op);
         expander_strobe <= !(active && n_exp && in_win(next_tick, EXP_OFF, STB_OFF));
      end
   end

   // ----------------------------------------
   // Bus, ports and latches
   // ----------------------------------------
   // Quasi pins drive only low; a one is left to the external pull-up
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         muxed_bus_pins <= '0;
         port_one_pins <= '0;
         port_two_pins <= '0;
         p1_latch <= PORT_RST;
         p2_latch <= PORT_RST;
         static_val <= BUS_RST;
         static_on <= 1'b0;
      end
      else
      begin
         muxed_bus_pins.level <= n_bus_val;
         muxed_bus_pins.oe <= {8{n_bus_oe}};
         port_one_pins.level <= p1_latch;
         port_one_pins.oe <= ~p1_latch;
         port_two_pins.level <= {p2_latch[7:4], n_p2_val};
         port_two_pins.oe <= {~p2_latch[7:4], n_p2_oe};
         if (req_take && (req.op == MEBPC_PORT_WR) && !req.port_two)
            p1_latch <= req.wdata;
         if (req_take && (req.op == MEBPC_PORT_WR) && req.port_two)
            p2_latch <= req.wdata;
         if (req_take && (req.op == MEBPC_BUS_WR))
         begin
            static_val <= req.wdata;
            static_on <= 1'b1;
         end
         else if (req_take && n_mem)
            static_on <= 1'b0;
      end
   end

   // ----------------------------------------
   // Answer to the core
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         resp <= '0;
      else
      begin
         resp.done <= active && (next_tick == STB_OFF) && (nop.op != MEBPC_IDLE);
         if ((state == MEBPC_RUN) && (tick == SAMPLE))
            resp.rdata <= sample_val;
      end
   end

   // ----------------------------------------
   // Interrupt and test pins
   // ----------------------------------------
   // Clock out toggles on every rising core edge; the pin mode has no way back but reset
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_en <= 1'b0;
         clkout_mode <= 1'b0;
         count_mode <= 1'b0;
         one_prev <= 1'b0;
         stat <= '0;
      end
      else
      begin
         if (ctl.int_enable)
            int_en <= 1'b1;
         else if (ctl.int_disable)
            int_en <= 1'b0;
         if (ctl.clkout_enable_instr)
            clkout_mode <= 1'b1;
         if (ctl.counter_start_instr)
            count_mode <= 1'b1;
         one_prev <= test_pin_one_in;
         stat <= next_stat;
      end
   end

   // ----------------------------------------
   // Clock output on test pin zero
   // ----------------------------------------
   // Half the core rate; the pin stays an input until the mode is set
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         test_pin_zero_out <= 1'b0;
         test_pin_zero_oe <= 1'b0;
      end
      else
      begin
         test_pin_zero_out <= clkout_mode && !test_pin_zero_out;
         test_pin_zero_oe <= clkout_mode;
      end
   end

endmodule : mebpc_top
`default_nettype wire

// ---- mebpc_properties.sv ----
// Port checker for the external bus pin controller.
// Assumes it is bound into mebpc_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module mebpc_properties
   import mebpc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire mebpc_req_t req,
   input wire logic req_take,
   input wire mebpc_resp_t resp,
   input wire mebpc_ctl_t ctl,
   input wire mebpc_stat_t stat,
   input wire mebpc_pin8_t muxed_bus_pins,
   input wire mebpc_pin8_t port_two_pins,
   input wire logic addr_latch,
   input wire logic code_fetch_strobe_n,
   input wire logic rd_strobe_n,
   input wire logic wr_strobe_n,
   input wire logic expander_strobe,
   input wire logic int_pin_n,
   input wire logic test_pin_zero_in
);
   logic [3:0] tick;
   logic int_en;
   logic any_stb;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   assign any_stb = !(rd_strobe_n && wr_strobe_n && code_fetch_strobe_n);
   // ----
   // Tick follower, saturates while halted
   // ----
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick <= 4'hF;
         int_en <= 1'b0;
      end
      else
      begin
         tick <= req_take ? 4'h0 : (tick == 4'hF ? tick : tick + 4'h1);
         int_en <= ctl.int_enable | (int_en & ~ctl.int_disable);
      end
   end
   ale_once_a: assert property (req_take |=> addr_latch [*3] ##1 !addr_latch [*8])
      else $error("latch pulse shape wrong");
   take_space_a: assert property (req_take |-> tick == 4'hE || tick == 4'hF)
      else $error("machine cycle length wrong");
   addr_setup_a: assert property ($fell(code_fetch_strobe_n) |->
      $past(muxed_bus_pins.oe[0], 2) && $past(addr_latch, 3))
      else $error("address not on bus at latch fall");
   fetch_len_a: assert property ($fell(code_fetch_strobe_n) |->
      !code_fetch_strobe_n [*7] ##1 code_fetch_strobe_n)
      else $error("fetch strobe width wrong");
   fetch_pins_a: assert property (!code_fetch_strobe_n |->
      muxed_bus_pins.oe == 8'h00 && port_two_pins.oe[3:0] == 4'hF)
      else $error("fetch pin directions wrong");
   rd_free_a: assert property (!rd_strobe_n |-> muxed_bus_pins.oe == 8'h00)
      else $error("bus driven during read");
   wr_data_a: assert property (!wr_strobe_n |->
      muxed_bus_pins.oe == 8'hFF && $stable(muxed_bus_pins.level))
      else $error("write data not steady");
   strobe_win_a: assert property (any_stb |-> tick inside {[4'h5:4'hB]} &&
      $onehot0({rd_strobe_n, wr_strobe_n, code_fetch_strobe_n} ^ 3'h7))
      else $error("strobe outside its window");
   exp_win_a: assert property ($fell(expander_strobe) |->
      tick == 4'h6 ##6 $rose(expander_strobe))
      else $error("expander strobe timing wrong");
   done_time_a: assert property (req_take && req.op != MEBPC_IDLE |-> ##13 resp.done)
      else $error("done late or missing");
   int_gate_a: assert property ($past(rst_n) |->
      stat.int_request == ($past(int_en) && !$past(int_pin_n)))
      else $error("interrupt request not gated");
   test_zero_a: assert property ($past(rst_n) |->
      stat.jump_if_test_zero_high == $past(test_pin_zero_in) &&
      stat.jump_if_test_zero_low != $past(test_pin_zero_in))
      else $error("test pin zero status wrong");
   cover property ($fell(code_fetch_strobe_n));
   cover property ($rose(stat.halted));
   cover property ($fell(expander_strobe));
endmodule : mebpc_properties
bind mebpc_top mebpc_properties u_props (.core_clk, .rst_n, .req, .req_take, .resp, .ctl,
   .stat, .muxed_bus_pins, .port_two_pins, .addr_latch, .code_fetch_strobe_n, .rd_strobe_n,
   .wr_strobe_n, .expander_strobe, .int_pin_n, .test_pin_zero_in);
`default_nettype wire

// ---- mebpc_ext_mem.sv ----
// External code and data memory with a four port nibble expander.
// Assumes pins change just after core_clk rises; released lines invert.
`timescale 1ns/100ps
`default_nettype none
module mebpc_ext_mem
   import mebpc_pkg::*;
(
   input wire logic core_clk,
   input wire mebpc_pin8_t bus,
   input wire mebpc_pin8_t p2,
   input wire logic addr_latch,
   input wire logic code_fetch_strobe_n,
   input wire logic rd_strobe_n,
   input wire logic wr_strobe_n,
   input wire logic expander_strobe,
   output logic [7:0] bus_wire,
   output logic [3:0] nib_wire
);
   logic [7:0] dmem [256];
   logic [3:0] xp [4];
   logic [11:0] adr;
   logic adr_ok, ale_q, stb_q;
   logic [3:0] cmd, xd, last_n, nib;
   logic [7:0] drv, last_b;
   initial
   begin
      for (int i = 0; i < 256; i++) dmem[i] = ~i[7:0];
      for (int i = 0; i < 4; i++) xp[i] = 4'h0;
   end
   // ----
   // Wire levels, no bus keeper on either side
   // ----
   assign drv = !code_fetch_strobe_n ? (adr[7:0] ^ 8'h5A ^ {4'h0, adr[11:8]}) :
      (adr_ok ? dmem[adr[7:0]] : 8'hC3);
   assign bus_wire = bus.oe[0] ? bus.level :
      ((!rd_strobe_n || !code_fetch_strobe_n) ? drv : ~last_b);
   assign nib = (!expander_strobe && cmd[3:2] == 2'b00) ? xp[cmd[1:0]] : ~last_n;
   assign nib_wire = (p2.oe[3:0] & p2.level[3:0]) | (~p2.oe[3:0] & nib);
   always @(posedge core_clk)
   begin
      ale_q <= addr_latch;
      stb_q <= expander_strobe;
      last_b <= bus_wire;
      last_n <= nib_wire;
      if (ale_q && !addr_latch)
      begin
         adr <= {p2.level[3:0], bus.level};
         adr_ok <= bus.oe[0];
      end
      if (!wr_strobe_n && adr_ok) dmem[adr[7:0]] <= bus.level;
      if (expander_strobe) cmd <= p2.level[3:0];
      if (!expander_strobe) xd <= p2.level[3:0];
      if (expander_strobe && !stb_q)
      begin
         case (cmd[3:2])
            2'b01: xp[cmd[1:0]] <= xd;
            2'b10: xp[cmd[1:0]] <= xp[cmd[1:0]] | xd;
            2'b11: xp[cmd[1:0]] <= xp[cmd[1:0]] & xd;
            default: ;
         endcase
      end
   end
endmodule : mebpc_ext_mem
`default_nettype wire

// ---- mebpc_tb.sv ----
// Self-checking bench for the external bus pin controller.
// Assumes the memory model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb
   import mebpc_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   mebpc_req_t req;
   mebpc_resp_t resp;
   mebpc_ctl_t ctl;
   mebpc_stat_t stat;
   mebpc_pin8_t bus_p, p1_p, p2_p;
   logic [7:0] icb, bus_in, p1_in, p2_in, ext1, ext2;
   logic req_take, ale, fetch_n, rd_n, wr_n, xstb, eff, ss_n, int_n, tz, tz_out, tz_oe, tpo, ie;
   logic [3:0] nib;
   logic [31:0] seed = 32'h00004FF5;
   logic [7:0] dm [256];
   logic [7:0] pl [2];
   logic [3:0] xm [4];
   int n_mismatch = 0;
   int checked = 0;
   always #2.5 core_clk = ~core_clk;
   assign p1_in = (p1_p.oe & p1_p.level) | (~p1_p.oe & ext1);
   assign p2_in = {(p2_p.oe[7:4] & p2_p.level[7:4]) | (~p2_p.oe[7:4] & ext2[7:4]), nib};
   mebpc_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .req(req), .req_take(req_take),
      .resp(resp), .ctl(ctl), .stat(stat), .int_code_byte(icb), .muxed_bus_in(bus_in),
      .muxed_bus_pins(bus_p), .port_one_in(p1_in), .port_one_pins(p1_p), .port_two_in(p2_in),
      .port_two_pins(p2_p), .addr_latch(ale), .code_fetch_strobe_n(fetch_n),
      .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .expander_strobe(xstb), .ext_fetch_force(eff),
      .single_step_n(ss_n), .int_pin_n(int_n), .test_pin_zero_in(tz),
      .test_pin_zero_out(tz_out), .test_pin_zero_oe(tz_oe), .test_pin_one_in(tpo));
   mebpc_ext_mem u_mem (.core_clk(core_clk), .bus(bus_p), .p2(p2_p), .addr_latch(ale),
      .code_fetch_strobe_n(fetch_n), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n),
      .expander_strobe(xstb), .bus_wire(bus_in), .nib_wire(nib));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   // ----
   // One machine cycle with a request, checked at done
   // ----
   task automatic run(input mebpc_op_t op, input logic [11:0] a, input logic [7:0] wd,
      input logic [1:0] cd, input logic ss);
      logic [7:0] r, ex, m;
      int w;
      r = rnd();
      m = 8'hFF;
      {int_n, tpo, tz} = r[2:0];
      eff = r[5];
      ext1 = rnd();
      ext2 = rnd();
      icb = rnd();
      ctl = {r[3], r[4], 2'b00};
      ie = r[3] | (ie & ~r[4]);
      @(posedge core_clk);
      #1;
      ctl = '0;
      req = '{op, a, wd, cd, a[1:0], a[4], 1'b1};
      w = 0;
      while (req_take !== 1'b1 && w < 40)
      begin
         @(posedge core_clk);
         #1;
         w++;
      end
      @(posedge core_clk);
      #1;
      req.op = MEBPC_IDLE;
      ss_n = !ss;
      repeat (12) @(posedge core_clk);
      #1;
      case (op)
         MEBPC_FETCH: ex = (a >= INT_CODE_SIZE || eff) ? (a[7:0] ^ 8'h5A ^ {4'h0, a[11:8]}) : icb;
         MEBPC_DATA_RD: ex = dm[a[7:0]];
         MEBPC_BUS_RD: ex = 8'hC3;
         MEBPC_PORT_RD: ex = pl[a[4]] & (a[4] ? ext2 : ext1);
         MEBPC_EXP_RD: ex = {4'h0, xm[a[1:0]]};
         default: m = 8'h00;
      endcase
      if (op == MEBPC_PORT_RD && a[4]) m = 8'hF0;
      if (op != MEBPC_IDLE) chk("done", 8'h01, {7'h00, resp.done});
      if (m != 8'h00) chk(op.name(), ex & m, resp.rdata & m);
      chk("stat", {tz, !tz, tpo, !tpo, !int_n, ie & !int_n, 2'b00}, {stat[7:2], 2'b00});
      if (op == MEBPC_DATA_WR) dm[a[7:0]] = wd;
      if (op == MEBPC_BUS_WR) dm[wd] = wd;
      if (op == MEBPC_BUS_WR) chk("bus_static", wd, bus_p.level & bus_p.oe);
      if (op == MEBPC_PORT_WR) pl[a[4]] = wd;
      if (op == MEBPC_EXP_WR) xm[a[1:0]] = cd == 2'b01 ? wd[3:0] :
         (cd == 2'b10 ? xm[a[1:0]] | wd[3:0] : xm[a[1:0]] & wd[3:0]);
      if (ss)
      begin
         repeat (4) @(posedge core_clk);
         #1;
         chk("halt", 8'h04, {5'h00, stat.halted, ale, req_take});
         ss_n = 1'b1;
      end
   endtask : run
   initial
   begin
      // Far beyond 60 cycles of 15 clocks plus the pin checks
      #100000;
      n_mismatch++;
      close_out();
   end
   initial
   begin
      static mebpc_op_t ops [10] = '{MEBPC_FETCH, MEBPC_DATA_WR, MEBPC_DATA_RD, MEBPC_BUS_WR,
         MEBPC_BUS_RD, MEBPC_PORT_WR, MEBPC_PORT_RD, MEBPC_EXP_WR, MEBPC_EXP_RD, MEBPC_IDLE};
      logic [11:0] a;
      logic [7:0] r;
      logic seen;
      req = '0;
      ctl = '0;
      {icb, ext1, ext2} = '0;
      {eff, tz, tpo, ie, seen} = '0;
      {ss_n, int_n} = 2'b11;
      for (int i = 0; i < 256; i++) dm[i] = ~i[7:0];
      for (int i = 0; i < 4; i++) xm[i] = 4'h0;
      pl = '{8'hFF, 8'hFF};
      repeat (4) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 60; i++)
      begin
         r = rnd();
         if (i % 10 == 0) a = {r[3:0], rnd()};
         run(ops[i % 10], a, rnd(), ops[i % 10] == MEBPC_EXP_WR ?
            (r[5:4] == 2'b00 ? 2'b01 : r[5:4]) : 2'b00, i % 7 == 6);
      end
      ctl.clkout_enable_instr = 1'b1;
      ctl.counter_start_instr = 1'b1;
      tpo = 1'b1;
      @(posedge core_clk);
      #1;
      ctl = '0;
      repeat (3) @(posedge core_clk);
      #1;
      r = {6'h00, tz_oe, tz_out};
      tpo = 1'b0;
      @(posedge core_clk);
      #1;
      // The event pulse stands for this one cycle only
      seen = stat.counter_event;
      chk("clkout", {6'h00, 1'b1, ~r[0]}, {6'h00, tz_oe, tz_out});
      repeat (3)
      begin
         @(posedge core_clk);
         #1;
         seen = seen | stat.counter_event;
      end
      chk("count_event", 8'h01, {7'h00, seen});
      close_out();
   end
endmodule : tb
`default_nettype wire
